// file: core/sdi_dev.sv
// converter serial front end: shift, input register, latch, decoder
// assumes link pins are asynchronous and sampled by clock
// What this block does
// - words, shift, input and latch registers are sixteen bits; segment outputs fifteen, ladder twelve
// - reset loads mid-scale into input and latch
// - shift register has no reset value
// - longer frames keep last sixteen bits
// - short frames leave old bits in place
// - host pads short data, first load full
// - chip select high ignores clock and data
// - host is master, drives clock and select
// - host changes data on falling clock
// - sample rising clock edge, MSB first
// - select rising copies shift to input register
// - host sends sixteen clocks then raises select
// - extra clocks: last sixteen bits transferred
// - broken frame needs fresh full word
// - load low with select high copies input register to latch
// - host holds load high during frame
// - load tied low updates after select rise
// - host waits four clocks after select rise, then holds load low four clocks (200 ns)
// - host keeps bit rate under limit
// - latch code is plain unsigned binary
// - upper nibble thermometer, low twelve to ladder
`timescale 1ns/100ps
`default_nettype none
module sdi_dev
  import sdi_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  sdi_link_if.dev                  link,
  output var  logic [WORD_W-1:0]   latch_code,
  output var  logic [SEG_W-1:0]    seg_sw,
  output var  logic [LADDER_W-1:0] ladder_sw
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] cs_s_reg, sck_s_reg, sd_s_reg, ld_s_reg;
  logic [2:0] cs_s_next, sck_s_next, sd_s_next, ld_s_next;
  always_comb
  begin
    cs_s_next  = {cs_s_reg[1:0], link.cs_n};
    sck_s_next = {sck_s_reg[1:0], link.sck};
    sd_s_next  = {sd_s_reg[1:0], link.sdata};
    ld_s_next  = {ld_s_reg[1:0], link.latch_load_n};
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cs_s_reg  <= 3'h7;
      sck_s_reg <= 3'h0;
      sd_s_reg  <= 3'h0;
      ld_s_reg  <= 3'h7;
    end
    else
    begin
      cs_s_reg  <= cs_s_next;
      sck_s_reg <= sck_s_next;
      sd_s_reg  <= sd_s_next;
      ld_s_reg  <= ld_s_next;
    end
  end
  // bit 0 is the metastable stage; only bits 1 and 2 are read
  logic cs_rise, sck_rise, cs_low;
  assign cs_low   = ~cs_s_reg[1];
  assign cs_rise  = cs_s_reg[1] & ~cs_s_reg[2];
  assign sck_rise = sck_s_reg[1] & ~sck_s_reg[2];

  // ----------------------------------------
  // shift, input register, latch
  // ----------------------------------------
  logic [WORD_W-1:0] shift_reg, shift_next;
  logic [WORD_W-1:0] input_reg, input_next;
  logic [WORD_W-1:0] latch_reg, latch_next;
  logic              pend_reg, pend_next;
  always_comb
  begin
    shift_next = shift_reg;
    if (cs_low && sck_rise)
      shift_next = {shift_reg[WORD_W-2:0], sd_s_reg[1]};
    input_next = input_reg;
    pend_next  = pend_reg;
    if (cs_rise)
    begin
      input_next = shift_reg;
      pend_next  = 1'b1;
    end
    latch_next = latch_reg;
    // pending load lets a held-low load pin follow each new word
    if (!ld_s_reg[1] && !cs_low && pend_reg)
    begin
      latch_next = input_reg;
      pend_next  = cs_rise;
    end
  end
  // shift register keeps no reset: contents undefined until shifted
  always_ff @(posedge clock)
    shift_reg <= shift_next;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      input_reg <= MID_CODE;
      latch_reg <= MID_CODE;
      pend_reg  <= 1'b0;
    end
    else
    begin
      input_reg <= input_next;
      latch_reg <= latch_next;
      pend_reg  <= pend_next;
    end
  end

  // ----------------------------------------
  // segment decoder
  // ----------------------------------------
  logic [SEG_W-1:0]    seg_next;
  logic [LADDER_W-1:0] lad_next;
  always_comb
  begin
    for (int i = 0; i < SEG_W; i++)
      seg_next[i] = (latch_reg[WORD_W-1 -: 4] > 4'(i));
    lad_next = latch_reg[LADDER_W-1:0];
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      latch_code <= MID_CODE;
      seg_sw     <= 15'h00FF;
      ladder_sw  <= 12'h000;
    end
    else
    begin
      latch_code <= latch_reg;
      seg_sw     <= seg_next;
      ladder_sw  <= lad_next;
    end
  end
endmodule : sdi_dev
`default_nettype wire

// file: core/sdi_host.sv
// host master end: sends one sixteen-bit word per request
// assumes requests come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module sdi_host
  import sdi_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              req,
  input  wire logic [WORD_W-1:0] req_word,
  input  wire logic              use_load,
  output var  logic              busy,
  sdi_link_if.host               link
);
  sdi_host_state_t   st_reg, st_next;
  logic [WORD_W-1:0] word_reg, word_next;
  logic [4:0]        bit_reg, bit_next;
  logic [3:0]        div_reg, div_next;
  logic              cs_reg, cs_next, sck_reg, sck_next, sd_reg, sd_next, ld_reg, ld_next, lu_reg, lu_next;
  logic              tick;
  // ----------------------------------------
  // half-period divider; slow clock keeps well under bit-rate limit
  // ----------------------------------------
  assign tick = (div_reg == SCK_HALF_M1);
  always_comb
  begin
    div_next  = tick ? 4'h0 : div_reg + 4'h1;
    st_next   = st_reg;
    word_next = word_reg;
    bit_next  = bit_reg;
    cs_next   = cs_reg;
    sck_next  = sck_reg;
    sd_next   = sd_reg;
    ld_next   = ld_reg;
    lu_next   = lu_reg;
    unique case (st_reg)
      SDI_IDLE:
        if (req)
        begin
          word_next = req_word;
          lu_next   = use_load;
          bit_next  = 5'h0;
          cs_next   = 1'b0;
          sd_next   = req_word[WORD_W-1];
          div_next  = 4'h0;
          st_next   = SDI_SHIFT;
        end
      SDI_SHIFT:
        if (tick)
        begin
          sck_next = ~sck_reg;
          if (sck_reg)
          begin
            if (bit_reg == BIT_LAST)
            begin
              cs_next = 1'b1;
              st_next = SDI_GAP;
            end
            else
            begin
              bit_next  = bit_reg + 5'h1;
              word_next = {word_reg[WORD_W-2:0], 1'b0};
              sd_next   = word_reg[WORD_W-2];
            end
          end
        end
      SDI_GAP:
        if (tick)
        begin
          bit_next = 5'h0;
          if (lu_reg)
          begin
            ld_next = 1'b0;
            st_next = SDI_LOAD;
          end
          else
            st_next = SDI_DONE;
        end
      SDI_LOAD:
        if (tick)
        begin
          ld_next = 1'b1;
          st_next = SDI_DONE;
        end
      SDI_DONE:
        if (tick)
          st_next = SDI_IDLE;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg   <= SDI_IDLE;
      word_reg <= 16'h0000;
      bit_reg  <= 5'h00;
      div_reg  <= 4'h0;
      cs_reg   <= 1'b1;
      sck_reg  <= 1'b0;
      sd_reg   <= 1'b0;
      ld_reg   <= 1'b1;
      lu_reg   <= 1'b0;
      busy     <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      word_reg <= word_next;
      bit_reg  <= bit_next;
      div_reg  <= div_next;
      cs_reg   <= cs_next;
      sck_reg  <= sck_next;
      sd_reg   <= sd_next;
      ld_reg   <= ld_next;
      lu_reg   <= lu_next;
      busy     <= (st_next != SDI_IDLE);
    end
  end
  assign link.cs_n         = cs_reg;
  assign link.sck          = sck_reg;
  assign link.sdata        = sd_reg;
  assign link.latch_load_n = ld_reg;
endmodule : sdi_host
`default_nettype wire

// file: core/sdi_link_if.sv
// link wires between the host master and the converter front end
// assumes both ends sample these with their own clock
`timescale 1ns/100ps
`default_nettype none
interface sdi_link_if;
  logic cs_n;
  logic sck;
  logic sdata;
  logic latch_load_n;
  modport host (output cs_n, output sck, output sdata, output latch_load_n);
  modport dev  (input cs_n, input sck, input sdata, input latch_load_n);
endinterface : sdi_link_if
`default_nettype wire

// file: core/sdi_pkg.sv
// package for the serial converter input interface
// assumes one 20 MHz system clock shared by both ends
package sdi_pkg;
  localparam int WORD_W = 16;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam int SEG_W = 15;
  localparam int LADDER_W = 12;
  localparam int CLK_NS = 50;
  localparam int LOAD_MIN_NS = 30;
  localparam int LOAD_CYC = (LOAD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF = 4;
  localparam logic [3:0] SCK_HALF_M1 = 4'(SCK_HALF - 1);
  localparam logic [4:0] BIT_LAST = 5'(WORD_W - 1);
  localparam logic [3:0] LOAD_CYC_M1 = 4'(LOAD_CYC);
  typedef enum logic [2:0] {
    SDI_IDLE,
    SDI_SHIFT,
    SDI_GAP,
    SDI_LOAD,
    SDI_DONE
  } sdi_host_state_t;
endpackage : sdi_pkg

// file: dv/sdi_link_monitor.sv
// checker on the link wires and the converter outputs
// assumes one shared clock and a synchronous high reset
`timescale 1ns/100ps
`default_nettype none
module sdi_link_monitor
  import sdi_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                cs_n,
  input wire logic                sck,
  input wire logic                sdata,
  input wire logic                latch_load_n,
  input wire logic [WORD_W-1:0]   latch_code,
  input wire logic [SEG_W-1:0]    seg_sw,
  input wire logic [LADDER_W-1:0] ladder_sw
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [4:0]        edges_reg;
  logic [4:0]        edges_next;
  logic              sck_reg;
  // ----
  // helpers
  // ----
  // counts sck rises in a frame; cleared while deselected
  always_comb
  begin
    edges_next = edges_reg;
    if (cs_n)
      edges_next = 5'h00;
    else if (sck && !sck_reg)
      edges_next = edges_reg + 5'h01;
  end
  always_ff @(posedge clock)
  begin
    sck_reg  <= sck;
    edges_reg <= edges_next;
  end
  sequence load_pulse_s;
    (!latch_load_n)[*4] ##1 latch_load_n;
  endsequence
  // decoder outputs and latch_code are all registered from the latch in the same edge
  reset_mid_a: assert property ($fell(rst) |-> latch_code == MID_CODE)
    else $error("latch not mid-scale");
  ladder_map_a: assert property (ladder_sw == latch_code[11:0])
    else $error("ladder wrong");
  seg_therm_a: assert property (seg_sw == 15'(15'h7FFF >> (4'hF - latch_code[15:12])))
    else $error("segments wrong");
  latch_hold_a: assert property (latch_load_n[*8] |=> $stable(latch_code))
    else $error("latch moved");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("sck outside frame");
  sck_half_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("sck half wrong");
  data_stable_a: assert property (sck |-> $stable(sdata))
    else $error("data moved");
  load_hold_a: assert property (!cs_n |-> latch_load_n)
    else $error("load in frame");
  load_pulse_a: assert property ($fell(latch_load_n) |-> $past(cs_n) ##0 load_pulse_s)
    else $error("load pulse wrong");
  frame_count_a: assert property ($rose(cs_n) |-> edges_reg == 5'h10)
    else $error("frame not 16");
endmodule : sdi_link_monitor
`default_nettype wire

// file: dv/serial_dac_input_interface_tb.sv
// bench: host end drives converter end over the link
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
module serial_dac_input_interface_tb
  import sdi_pkg::*;
();
  logic                clock;
  logic                rst;
  logic                req;
  logic [WORD_W-1:0]   req_word;
  logic                use_load;
  logic                busy;
  logic [WORD_W-1:0]   latch_code;
  logic [SEG_W-1:0]    seg_sw;
  logic [LADDER_W-1:0] ladder_sw;
  int                  fails = 0;
  int                  compares = 0;
  logic [WORD_W-1:0]   words [4] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h7FFF};
  sdi_link_if lk ();
  sdi_host i_sdi_host (.clock(clock), .rst(rst), .req(req), .req_word(req_word),
    .use_load(use_load), .busy(busy), .link(lk));
  sdi_dev i_sdi_dev (.clock(clock), .rst(rst), .link(lk), .latch_code(latch_code),
    .seg_sw(seg_sw), .ladder_sw(ladder_sw));
  sdi_link_monitor i_sdi_link_monitor (.clock(clock), .rst(rst), .cs_n(lk.cs_n), .sck(lk.sck),
    .sdata(lk.sdata), .latch_load_n(lk.latch_load_n), .latch_code(latch_code),
    .seg_sw(seg_sw), .ladder_sw(ladder_sw));
  // ----
  // tasks
  // ----
  task automatic end_of_test();
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_out(input logic [15:0] w);
    chk("latch", w, latch_code);
    chk("seg", {1'b0, 15'(15'h7FFF >> (4'hF - w[15:12]))}, {1'b0, seg_sw});
    chk("ladder", {4'h0, w[11:0]}, {4'h0, ladder_sw});
  endtask : chk_out
  // one whole frame; busy wait is bounded so a hang shows as a mismatch
  task automatic send(input logic [15:0] w, input logic ld);
    int n;
    req = 1'b1;
    req_word = w;
    use_load = ld;
    @(negedge clock);
    req = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 4)
    begin
      @(negedge clock);
      n++;
    end
    while (busy !== 1'b0 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    chk("busy", 16'h0000, {15'h0000, busy});
  endtask : send
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    req = 1'b0;
    req_word = 16'h0000;
    use_load = 1'b0;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk_out(MID_CODE);
    send(16'h1234, 1'b0);
    chk_out(MID_CODE);
    send(16'hABCD, 1'b1);
    chk_out(16'hABCD);
    foreach (words[i])
    begin
      send(words[i], 1'b1);
      chk_out(words[i]);
    end
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk_out(MID_CODE);
    end_of_test();
  end
endmodule : serial_dac_input_interface_tb
`default_nettype wire
